// ### include/rcap_cfg.svh
// Constants for the registered command and address path
`ifndef RCAP_CFG_SVH
`define RCAP_CFG_SVH
`define RCAP_ADDR_W 18
`define RCAP_RANKS 4
`define RCAP_CMD_MRS 4'h8
`define RCAP_CW_BANK 2'h3
`define RCAP_CW_IDX_HI 11
`define RCAP_CW_IDX_LO 8
`define RCAP_CW_DAT_HI 7
`define RCAP_CW_DAT_LO 0
`define RCAP_CW_WORDS 16
`define RCAP_CW_PARITY 4'he
`define RCAP_CW_MODULE 4'h0
`define RCAP_PAR_EN_BIT 0
`define RCAP_MODE_HI 1
`define RCAP_MODE_LO 0
`define RCAP_CW_RST 8'h00
`define RCAP_ALERT_CYC 6'h30
`define RCAP_I2C_DEV 7'h58
`define RCAP_CLK_NS 8
`define RCAP_CK_HALF_NS 80
`define RCAP_CK_HALF_CYC ((`RCAP_CK_HALF_NS + `RCAP_CLK_NS - 1) / `RCAP_CLK_NS)
`define RCAP_I2C_Q_NS 250
`define RCAP_I2C_Q_CYC ((`RCAP_I2C_Q_NS + `RCAP_CLK_NS - 1) / `RCAP_CLK_NS)
`define RCAP_I2C_BITS 27
`endif

// ### include/rcap_pkg.sv
// Types and shared address swap functions
package rcap_pkg;
    // Four-state base so the mode can ride on a net
    typedef enum logic [1:0] {RCAP_TWO_SEL, RCAP_FOUR_DIRECT, RCAP_FOUR_ENC} rcap_rank_mode_t;
    typedef enum {RCAP_I2C_IDLE, RCAP_I2C_START, RCAP_I2C_SEND, RCAP_I2C_STOP} rcap_i2c_state_t;

    function automatic rcap_rank_mode_t decode_mode(input logic [1:0] f);
        unique case (f)
            2'h1:    decode_mode = RCAP_FOUR_DIRECT;
            2'h2:    decode_mode = RCAP_FOUR_ENC;
            default: decode_mode = RCAP_TWO_SEL;
        endcase
    endfunction

    // Mirrored wiring of address lines; its own inverse
    function automatic logic [17:0] mirror_addr(input logic [17:0] a);
        logic [17:0] m;
        m = a;
        m[3] = a[4];
        m[4] = a[3];
        m[5] = a[6];
        m[6] = a[5];
        m[7] = a[8];
        m[8] = a[7];
        m[11] = a[13];
        m[13] = a[11];
        mirror_addr = m;
    endfunction

    function automatic logic [1:0] mirror_pair(input logic [1:0] p);
        mirror_pair = {p[0], p[1]};
    endfunction
endpackage

// ### include/rcap_link_if.sv
// Command bus, alert and two-wire control link between controller and driver
`include "rcap_cfg.svh"
interface rcap_link_if;
    logic                     ck;
    logic [3:0]               csN;
    logic [3:0]               cmdN;
    logic [`RCAP_ADDR_W-1:0]  addr;
    logic [1:0]               ba;
    logic [1:0]               bg;
    logic                     par;
    logic                     alertOut;
    logic                     alertOe;
    logic                     sclOut;
    logic                     sclOe;
    logic                     sdaHostOut;
    logic                     sdaHostOe;
    logic                     sdaDevOut;
    logic                     sdaDevOe;
    // Open-drain wires: low while any party enables its driver
    wire alertN = ~alertOe;
    wire scl = ~sclOe;
    wire sda = ~(sdaHostOe | sdaDevOe);

    modport dev (input ck, csN, cmdN, addr, ba, bg, par, alertN, scl, sda,
                 output alertOut, alertOe, sdaDevOut, sdaDevOe);
    modport host (output ck, csN, cmdN, addr, ba, bg, par, sclOut, sclOe, sdaHostOut, sdaHostOe,
                  input alertN, scl, sda);
endinterface

// ### hw/rcap_clock_driver.sv
// Registering clock driver end: parity check, rank routing, mirroring, control words
`include "rcap_cfg.svh"

module rcap_clock_driver #(
    parameter int CK_PAIRS = 4
) (
    input  wire logic                                    clk_sys,
    input  wire logic                                    rst_b,
    rcap_link_if.dev                                     link,
    output logic [CK_PAIRS-1:0]                          dramCkT,
    output logic [CK_PAIRS-1:0]                          dramCkC,
    output logic                                         dramValid,
    output logic [`RCAP_RANKS-1:0]                       dramCsN,
    output logic [3:0]                                   dramCmdN,
    output logic [`RCAP_RANKS-1:0][`RCAP_ADDR_W-1:0]     dramAddr,
    output logic [`RCAP_RANKS-1:0][1:0]                  dramBa,
    output logic [`RCAP_RANKS-1:0][1:0]                  dramBg,
    output logic                                         parErrFlag,
    output logic                                         parEnable,
    output logic [1:0]                                   rankModeField
);
    localparam int BW = 1 + 4 + 4 + `RCAP_ADDR_W + 2 + 2 + 1;

    ////////////////////////////////////////////////////////////////////////
    logic [BW-1:0]              pinS1;
    logic [BW-1:0]              pinS2;
    logic                       ckPrev;
    logic                       ckIn;
    logic [3:0]                 csIn;
    logic [3:0]                 cmdIn;
    logic [`RCAP_ADDR_W-1:0]    addrIn;
    logic [1:0]                 baIn;
    logic [1:0]                 bgIn;
    logic                       parIn;
    logic [`RCAP_CW_DAT_HI:0]   cwMem [`RCAP_CW_WORDS];
    logic [5:0]                 alertCnt_reg;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pinS1  <= '0;
            pinS2  <= '0;
            ckPrev <= 1'b0;
        end else begin
            pinS1  <= {link.ck, link.csN, link.cmdN, link.addr, link.ba, link.bg, link.par};
            pinS2  <= pinS1;
            ckPrev <= ckIn;
        end
    end

    assign {ckIn, csIn, cmdIn, addrIn, baIn, bgIn, parIn} = pinS2;

    ////////////////////////////////////////////////////////////////////////
    // Decode of the sampled command
    wire                        ckRise = ckIn & ~ckPrev;
    wire logic                  parEn = cwMem[`RCAP_CW_PARITY][`RCAP_PAR_EN_BIT];
    wire logic [1:0]            modeField = cwMem[`RCAP_CW_MODULE][`RCAP_MODE_HI:`RCAP_MODE_LO];
    wire rcap_pkg::rcap_rank_mode_t rankMode = rcap_pkg::decode_mode(modeField);
    logic [`RCAP_RANKS-1:0]     rankHit;

    always_comb begin
        unique case (rankMode)
            rcap_pkg::RCAP_TWO_SEL:     rankHit = {2'b00, ~csIn[1:0]};
            rcap_pkg::RCAP_FOUR_DIRECT: rankHit = ~csIn;
            rcap_pkg::RCAP_FOUR_ENC:    rankHit = csIn[0] ? 4'h0 : (4'h1 << csIn[3:2]);
            default:                    rankHit = 4'h0;
        endcase
    end

    wire selAny = |rankHit;
    wire parErr = parIn ^ (^{cmdIn, addrIn, baIn, bgIn});
    wire isCw = (cmdIn == `RCAP_CMD_MRS) && (baIn == `RCAP_CW_BANK) && (bgIn == `RCAP_CW_BANK);
    wire cmdTaken = ckRise && selAny;
    wire badCmd = cmdTaken && parEn && parErr;
    wire fwd = cmdTaken && !(parEn && parErr);
    wire caWr = fwd && isCw;
    wire [3:0] caIdx = addrIn[`RCAP_CW_IDX_HI:`RCAP_CW_IDX_LO];
    wire [7:0] caDat = addrIn[`RCAP_CW_DAT_HI:`RCAP_CW_DAT_LO];

    ////////////////////////////////////////////////////////////////////////
    // DRAM side redrive, one clock after the sampling edge is seen
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            dramValid <= 1'b0;
            dramCsN   <= '1;
            dramCmdN  <= '1;
            dramAddr  <= '0;
            dramBa    <= '0;
            dramBg    <= '0;
            dramCkT   <= '0;
            dramCkC   <= '1;
        end else begin
            dramCkT   <= {CK_PAIRS{ckIn}};
            dramCkC   <= {CK_PAIRS{~ckIn}};
            dramValid <= fwd && !isCw;
            if (fwd && !isCw) begin
                dramCsN  <= ~rankHit;
                dramCmdN <= cmdIn;
                for (int r = 0; r < `RCAP_RANKS; r++) begin
                    // Odd ranks carry the crossed wiring; same swap both ways keeps data in place
                    dramAddr[r] <= r[0] ? rcap_pkg::mirror_addr(addrIn) : addrIn;
                    dramBa[r]   <= r[0] ? rcap_pkg::mirror_pair(baIn) : baIn;
                    dramBg[r]   <= r[0] ? rcap_pkg::mirror_pair(bgIn) : bgIn;
                end
            end else begin
                dramCsN <= '1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Two-wire write slave: device byte, word index, data
    logic                       sclS1;
    logic                       sclS2;
    logic                       sclP;
    logic                       sdaS1;
    logic                       sdaS2;
    logic                       sdaP;
    logic                       i2cAct_reg;
    logic                       ackOn_reg;
    logic [3:0]                 bitCnt_reg;
    logic [1:0]                 byteIdx_reg;
    logic [7:0]                 shift_reg;
    logic [3:0]                 i2cIdx_reg;

    wire i2cStart = sclS2 && sclP && sdaP && !sdaS2;
    wire i2cStop = sclS2 && sclP && !sdaP && sdaS2;
    wire sclRise = sclS2 && !sclP;
    wire sclFall = !sclS2 && sclP;
    wire byteDone = sclFall && i2cAct_reg && (bitCnt_reg == 4'h8) && !ackOn_reg;
    wire addrOk = shift_reg == {`RCAP_I2C_DEV, 1'b0};
    wire i2cWr = byteDone && (byteIdx_reg == 2'h2);

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            {sclS1, sclS2, sclP, sdaS1, sdaS2, sdaP} <= 6'h3f;
            i2cAct_reg  <= 1'b0;
            ackOn_reg   <= 1'b0;
            bitCnt_reg  <= 4'h0;
            byteIdx_reg <= 2'h0;
            shift_reg   <= 8'h00;
            i2cIdx_reg  <= 4'h0;
        end else begin
            sclS1 <= link.scl;
            sclS2 <= sclS1;
            sclP  <= sclS2;
            sdaS1 <= link.sda;
            sdaS2 <= sdaS1;
            sdaP  <= sdaS2;
            if (i2cStart) begin
                i2cAct_reg  <= 1'b1;
                ackOn_reg   <= 1'b0;
                bitCnt_reg  <= 4'h0;
                byteIdx_reg <= 2'h0;
            end else if (i2cStop) begin
                i2cAct_reg <= 1'b0;
                ackOn_reg  <= 1'b0;
            end else if (sclRise && i2cAct_reg && bitCnt_reg < 4'h8) begin
                shift_reg  <= {shift_reg[6:0], sdaS2};
                bitCnt_reg <= bitCnt_reg + 4'h1;
            end else if (byteDone) begin
                // Foreign device byte: stay silent until the next start
                ackOn_reg  <= (byteIdx_reg != 2'h0) || addrOk;
                i2cAct_reg <= (byteIdx_reg != 2'h0) || addrOk;
                if (byteIdx_reg == 2'h1) begin
                    i2cIdx_reg <= shift_reg[3:0];
                end
            end else if (sclFall && ackOn_reg) begin
                ackOn_reg   <= 1'b0;
                bitCnt_reg  <= 4'h0;
                byteIdx_reg <= (byteIdx_reg == 2'h2) ? 2'h2 : byteIdx_reg + 2'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control words and alert
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            for (int i = 0; i < `RCAP_CW_WORDS; i++) begin
                cwMem[i] <= `RCAP_CW_RST;
            end
            alertCnt_reg  <= '0;
            link.alertOe  <= 1'b0;
            link.sdaDevOe <= 1'b0;
            parErrFlag    <= 1'b0;
            parEnable     <= 1'b0;
            rankModeField <= 2'h0;
        end else begin
            // Command bus write wins a tie with the two-wire path
            if (caWr) begin
                cwMem[caIdx] <= caDat;
            end else if (i2cWr) begin
                cwMem[i2cIdx_reg] <= shift_reg;
            end
            if (badCmd) begin
                alertCnt_reg <= `RCAP_ALERT_CYC;
            end else if (alertCnt_reg != '0) begin
                alertCnt_reg <= alertCnt_reg - 6'h1;
            end
            link.alertOe  <= badCmd || (alertCnt_reg > 6'h1);
            link.sdaDevOe <= ackOn_reg;
            parErrFlag    <= badCmd;
            parEnable     <= parEn;
            rankModeField <= modeField;
        end
    end

    assign link.alertOut = 1'b0;
    assign link.sdaDevOut = 1'b0;
endmodule // rcap_clock_driver

// ### hw/rcap_host_ctrl.sv
// Controller end: command bus driver, link clock, parity, two-wire word writer
`include "rcap_cfg.svh"
module rcap_host_ctrl #(
    parameter int CK_HALF = `RCAP_CK_HALF_CYC,
    parameter int I2C_Q   = `RCAP_I2C_Q_CYC
) (
    input  wire logic                     clk_sys,
    input  wire logic                     rst_b,
    rcap_link_if.host                     link,
    input  wire logic                     reqValid,
    output logic                          reqReady,
    input  wire logic [1:0]               reqRank,
    input  wire logic [3:0]               reqCmdN,
    input  wire logic [`RCAP_ADDR_W-1:0]  reqAddr,
    input  wire logic [1:0]               reqBa,
    input  wire logic [1:0]               reqBg,
    input  wire logic                     reqBadPar,
    input  wire logic [1:0]               rankModeField,
    input  wire logic                     spdMirror,
    input  wire logic                     cwValid,
    output logic                          cwReady,
    input  wire logic [3:0]               cwIdx,
    input  wire logic [7:0]               cwData,
    output logic                          cwNack,
    output logic                          alertSeen
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0]                 ckCnt_reg;
    logic                       pend_reg;
    logic [3:0]                 pCs_reg;
    logic [3:0]                 pCmd_reg;
    logic [`RCAP_ADDR_W-1:0]    pAddr_reg;
    logic [1:0]                 pBa_reg;
    logic [1:0]                 pBg_reg;
    logic                       pPar_reg;
    logic                       alS1;
    logic                       alS2;

    wire ckFall = (ckCnt_reg == 8'(CK_HALF - 1)) && link.ck;
    wire rcap_pkg::rcap_rank_mode_t mode = rcap_pkg::decode_mode(rankModeField);
    wire [3:0] csEnc = (mode == rcap_pkg::RCAP_FOUR_ENC) ? {reqRank, 2'b10} : ~(4'h1 << reqRank);
    wire isMrs = reqCmdN == `RCAP_CMD_MRS;
    wire preSwap = spdMirror && reqRank[0] && isMrs;
    wire [`RCAP_ADDR_W-1:0] sAddr = preSwap ? rcap_pkg::mirror_addr(reqAddr) : reqAddr;
    wire [1:0] sBa = preSwap ? rcap_pkg::mirror_pair(reqBa) : reqBa;
    wire [1:0] sBg = preSwap ? rcap_pkg::mirror_pair(reqBg) : reqBg;
    wire sPar = (^{reqCmdN, sAddr, sBa, sBg}) ^ reqBadPar;

    // Pins change at the falling link edge, so they are settled at the rising one
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ckCnt_reg <= 8'h00;
            link.ck   <= 1'b0;
            pend_reg  <= 1'b0;
            reqReady  <= 1'b0;
            link.csN  <= '1;
            link.cmdN <= '1;
            link.addr <= '0;
            link.ba   <= '0;
            link.bg   <= '0;
            link.par  <= 1'b0;
            {pCs_reg, pCmd_reg, pAddr_reg, pBa_reg, pBg_reg, pPar_reg} <= '1;
            {alS1, alS2, alertSeen} <= 3'h0;
        end else begin
            ckCnt_reg <= (ckCnt_reg == 8'(CK_HALF - 1)) ? 8'h00 : ckCnt_reg + 8'h1;
            if (ckCnt_reg == 8'(CK_HALF - 1)) begin
                link.ck <= ~link.ck;
            end
            if (reqValid && reqReady) begin
                pend_reg <= 1'b1;
                {pCs_reg, pCmd_reg, pAddr_reg, pBa_reg, pBg_reg, pPar_reg} <=
                    {csEnc, reqCmdN, sAddr, sBa, sBg, sPar};
            end else if (ckFall) begin
                pend_reg <= 1'b0;
            end
            reqReady <= !pend_reg && !(reqValid && reqReady);
            if (ckFall) begin
                link.csN  <= pend_reg ? pCs_reg : 4'hf;
                link.cmdN <= pCmd_reg;
                link.addr <= pAddr_reg;
                link.ba   <= pBa_reg;
                link.bg   <= pBg_reg;
                link.par  <= pPar_reg;
            end
            alS1      <= ~link.alertN;
            alS2      <= alS1;
            alertSeen <= alS2;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Two-wire control word writer, four phases per bit
    rcap_pkg::rcap_i2c_state_t  st_reg;
    logic [7:0]                 qCnt_reg;
    logic [1:0]                 ph_reg;
    logic [4:0]                 bit_reg;
    logic [`RCAP_I2C_BITS-1:0]  frame_reg;
    logic                       sdS1;
    logic                       sdS2;

    wire qTick = qCnt_reg == 8'(I2C_Q - 1);
    wire ackSlot = (bit_reg == 5'd8) || (bit_reg == 5'd17) || (bit_reg == 5'd26);

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            st_reg         <= rcap_pkg::RCAP_I2C_IDLE;
            qCnt_reg       <= 8'h00;
            ph_reg         <= 2'h0;
            bit_reg        <= 5'h00;
            frame_reg      <= '1;
            link.sclOe     <= 1'b0;
            link.sdaHostOe <= 1'b0;
            cwReady        <= 1'b0;
            cwNack         <= 1'b0;
            {sdS1, sdS2}   <= 2'h3;
        end else begin
            sdS1     <= link.sda;
            sdS2     <= sdS1;
            qCnt_reg <= qTick ? 8'h00 : qCnt_reg + 8'h1;
            cwReady  <= (st_reg == rcap_pkg::RCAP_I2C_IDLE) && !(cwValid && cwReady);
            unique case (st_reg)
                rcap_pkg::RCAP_I2C_IDLE: begin
                    if (cwValid && cwReady) begin
                        frame_reg <= {`RCAP_I2C_DEV, 1'b0, 1'b1, 4'h0, cwIdx, 1'b1, cwData, 1'b1};
                        st_reg    <= rcap_pkg::RCAP_I2C_START;
                        cwNack    <= 1'b0;
                        ph_reg    <= 2'h0;
                    end
                end
                rcap_pkg::RCAP_I2C_START: if (qTick) begin
                    ph_reg <= ph_reg + 2'h1;
                    if (ph_reg == 2'h0) begin
                        link.sdaHostOe <= 1'b1;
                    end else begin
                        link.sclOe <= 1'b1;
                        st_reg     <= rcap_pkg::RCAP_I2C_SEND;
                        ph_reg     <= 2'h0;
                        bit_reg    <= 5'h00;
                    end
                end
                rcap_pkg::RCAP_I2C_SEND: if (qTick) begin
                    ph_reg <= ph_reg + 2'h1;
                    unique case (ph_reg)
                        2'h0: link.sdaHostOe <= ~frame_reg[`RCAP_I2C_BITS-1];
                        2'h1: link.sclOe <= 1'b0;
                        2'h2: cwNack <= cwNack || (ackSlot && sdS2);
                        2'h3: begin
                            link.sclOe <= 1'b1;
                            frame_reg  <= {frame_reg[`RCAP_I2C_BITS-2:0], 1'b1};
                            bit_reg    <= bit_reg + 5'h1;
                            if (bit_reg == 5'(`RCAP_I2C_BITS - 1)) begin
                                st_reg <= rcap_pkg::RCAP_I2C_STOP;
                            end
                        end
                    endcase
                end
                rcap_pkg::RCAP_I2C_STOP: if (qTick) begin
                    ph_reg <= ph_reg + 2'h1;
                    unique case (ph_reg)
                        2'h0: link.sdaHostOe <= 1'b1;
                        2'h1: link.sclOe <= 1'b0;
                        2'h2: link.sdaHostOe <= 1'b0;
                        2'h3: st_reg <= rcap_pkg::RCAP_I2C_IDLE;
                    endcase
                end
            endcase
        end
    end

    assign link.sclOut = 1'b0;
    assign link.sdaHostOut = 1'b0;
endmodule // rcap_host_ctrl

// ### bench/rcap_link_chk.sv
// Checker of the link between controller and driver ends
`include "rcap_cfg.svh"
module rcap_link_chk #(
    parameter int CK_HALF = 10
) (
    input wire logic                    clk_sys,
    input wire logic                    rst_b,
    input wire logic                    ck,
    input wire logic [3:0]              csN,
    input wire logic [3:0]              cmdN,
    input wire logic [`RCAP_ADDR_W-1:0] addr,
    input wire logic [1:0]              ba,
    input wire logic [1:0]              bg,
    input wire logic                    par,
    input wire logic                    alertOut,
    input wire logic                    alertOe,
    input wire logic                    scl,
    input wire logic                    sdaDevOe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] hiCnt_reg;
    logic [5:0] alCnt_reg;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////
    // Run lengths of link clock high phase and of alert
    always_ff @(posedge clk_sys) begin
        hiCnt_reg <= (!rst_b || !ck) ? 8'h00 : hiCnt_reg + 8'h01;
        alCnt_reg <= (!rst_b || !alertOe) ? 6'h00 : alCnt_reg + 6'h01;
    end
    sequence ckFall;
        $fell(ck);
    endsequence
    chk_ck_half: assert property ($fell(ck) |-> hiCnt_reg == CK_HALF)
        else $error("link clock high phase length wrong");
    chk_cs_launch: assert property ($changed(csN) |-> ckFall)
        else $error("chip selects changed off the falling link clock");
    chk_pin_launch: assert property ($changed({cmdN, addr, ba, bg, par}) |-> ckFall)
        else $error("command pins changed off the falling link clock");
    chk_alert_width: assert property ($fell(alertOe) |-> alCnt_reg == `RCAP_ALERT_CYC)
        else $error("alert pulse width wrong");
    chk_alert_bound: assert property (alCnt_reg <= `RCAP_ALERT_CYC)
        else $error("alert held too long");
    chk_alert_drain: assert property (alertOe |-> !alertOut)
        else $error("alert driven high");
    chk_alert_sample: assert property ($rose(alertOe) |-> ck)
        else $error("alert raised outside a sampled command");
    chk_ack_start: assert property ($rose(sdaDevOe) |-> !scl)
        else $error("ack started while serial clock high");
    chk_ack_end: assert property ($fell(sdaDevOe) |-> !scl)
        else $error("ack released while serial clock high");
endmodule // rcap_link_chk

// ### bench/testbench.sv
// Testbench joining controller and driver ends over the link
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin err_count++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic            clk_sys, rst_b, reqValid, reqReady, reqBadPar, spdMirror, cwValid, cwReady, cwNack, alertSeen;
    logic [1:0]      reqRank, reqBa, reqBg, hostMode, rankModeField;
    logic [3:0]      reqCmdN, cwIdx, lastCs, dramCkT, dramCkC, dramCsN, dramCmdN;
    logic [17:0]     reqAddr;
    logic [7:0]      cwData;
    logic [3:0][17:0] dramAddr;
    logic [3:0][1:0] dramBa, dramBg;
    logic            dramValid, parErrFlag, parEnable, sawAlert, ckOld;
    int              err_count, n_compared, nFwd, nErr, cyc, ckAge;
    rcap_link_if link();
    rcap_clock_driver u_rcap_clock_driver (.clk_sys, .rst_b, .link(link.dev), .dramCkT, .dramCkC, .dramValid,
        .dramCsN, .dramCmdN, .dramAddr, .dramBa, .dramBg, .parErrFlag, .parEnable, .rankModeField);
    rcap_host_ctrl #(.CK_HALF(10), .I2C_Q(4)) u_rcap_host_ctrl (.clk_sys, .rst_b, .link(link.host), .reqValid,
        .reqReady, .reqRank, .reqCmdN, .reqAddr, .reqBa, .reqBg, .reqBadPar, .rankModeField(hostMode), .spdMirror,
        .cwValid, .cwReady, .cwIdx, .cwData, .cwNack, .alertSeen);
    rcap_link_chk #(.CK_HALF(10)) u_rcap_link_chk (.clk_sys, .rst_b, .ck(link.ck), .csN(link.csN),
        .cmdN(link.cmdN), .addr(link.addr), .ba(link.ba), .bg(link.bg), .par(link.par), .alertOut(link.alertOut),
        .alertOe(link.alertOe), .scl(link.scl), .sdaDevOe(link.sdaDevOe));
    ////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Monitor counts forwards and errors; also cuts a hang short
    always @(posedge clk_sys) begin
        cyc++;
        // Cycles since the link clock was seen rising
        ckAge = (link.ck === 1'b1 && ckOld !== 1'b1) ? 0 : ckAge + 1;
        ckOld = link.ck;
        if (dramValid === 1'b1) begin
            nFwd++;
            lastCs = dramCsN;
            `CHK("fwd delay", 3, ckAge);
        end
        if (parErrFlag === 1'b1) nErr++;
        if (alertSeen === 1'b1) sawAlert = 1'b1;
        if (cyc == 20000) begin
            err_count++;
            report_and_stop();
        end
    end
    // Wait covers launch on link clock, sync and alert delay
    task automatic send(input logic [1:0] r, input logic [3:0] c, input logic [17:0] a, input logic [1:0] b,
                        input logic bad);
        @(negedge clk_sys);
        {reqRank, reqCmdN, reqAddr, reqBa, reqBg, reqBadPar} = {r, c, a, b, b, bad};
        reqValid = 1'b1;
        do @(posedge clk_sys); while (reqReady !== 1'b1);
        @(negedge clk_sys);
        reqValid = 1'b0;
        repeat (60) @(negedge clk_sys);
    endtask
    task automatic cw(input logic [3:0] i, input logic [7:0] d);
        @(negedge clk_sys);
        {cwIdx, cwData, cwValid} = {i, d, 1'b1};
        do @(posedge clk_sys); while (cwReady !== 1'b1);
        @(negedge clk_sys);
        cwValid = 1'b0;
        do @(posedge clk_sys); while (cwReady !== 1'b1);
        @(negedge clk_sys);
    endtask
    task automatic t_mirror;
        send(2'h0, 4'h7, 18'h008a8, 2'h1, 1'b0);
        `CHK("rank0 addr", 18'h008a8, dramAddr[0]);
        `CHK("rank0 cs", 4'he, lastCs);
        `CHK("rank0 cmd", 4'h7, dramCmdN);
        send(2'h1, 4'h7, 18'h008a8, 2'h1, 1'b0);
        `CHK("rank1 addr", 18'h02150, dramAddr[1]);
        `CHK("rank1 bank", 4'ha, {dramBa[1], dramBg[1]});
        `CHK("rank1 cs", 4'hd, lastCs);
        spdMirror = 1'b1;
        send(2'h1, 4'h8, 18'h008a8, 2'h1, 1'b0);
        `CHK("mode load addr", 18'h008a8, dramAddr[1]);
        spdMirror = 1'b0;
        `CHK("forwards", 3, nFwd);
        $display("t_mirror done");
    endtask
    task automatic t_parity;
        send(2'h0, 4'h8, 18'h00e01, 2'h3, 1'b0);
        `CHK("parity on", 1'b1, parEnable);
        `CHK("word not redriven", 3, nFwd);
        send(2'h0, 4'h7, 18'h00001, 2'h0, 1'b1);
        `CHK("bad dropped", 3, nFwd);
        `CHK("error pulse", 1, nErr);
        `CHK("alert seen", 1'b1, sawAlert);
        send(2'h0, 4'h7, 18'h00001, 2'h0, 1'b0);
        `CHK("good forwarded", 4, nFwd);
        send(2'h0, 4'h8, 18'h00001, 2'h3, 1'b1);
        `CHK("bad word refused", 2'h0, rankModeField);
        `CHK("bad word flagged", 2, nErr);
        cw(4'he, 8'h00);
        `CHK("parity off", 1'b0, parEnable);
        sawAlert = 1'b0;
        send(2'h0, 4'h7, 18'h00001, 2'h0, 1'b1);
        `CHK("bad forwarded", 5, nFwd);
        `CHK("no alert", 1'b0, sawAlert);
        $display("t_parity done");
    endtask
    task automatic t_mode;
        cw(4'h0, 8'h01);
        hostMode = 2'h1;
        `CHK("mode field", 2'h1, rankModeField);
        send(2'h3, 4'h7, 18'h008a8, 2'h1, 1'b0);
        `CHK("rank3 cs", 4'h7, lastCs);
        `CHK("rank3 addr", 18'h02150, dramAddr[3]);
        cw(4'h0, 8'h02);
        hostMode = 2'h2;
        send(2'h2, 4'h7, 18'h008a8, 2'h1, 1'b0);
        `CHK("rank2 cs", 4'hb, lastCs);
        `CHK("rank2 addr", 18'h008a8, dramAddr[2]);
        `CHK("clock pairs", ~dramCkT, dramCkC);
        `CHK("word ack", 1'b0, cwNack);
        @(posedge link.ck);
        repeat (4) @(negedge clk_sys);
        `CHK("clock pairs high", 8'hf0, {dramCkT, dramCkC});
        cw(4'h0, 8'h03);
        hostMode = 2'h0;
        send(2'h1, 4'h7, 18'h008a8, 2'h1, 1'b0);
        `CHK("mode3 rank1 cs", 4'hd, lastCs);
        $display("t_mode done");
    endtask
    task automatic report_and_stop;
        $display("Compared %0d, mismatched %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        {rst_b, reqValid, reqBadPar, spdMirror, cwValid, sawAlert} = 6'h00;
        {reqRank, reqBa, reqBg, hostMode, reqCmdN, cwIdx, lastCs} = 20'hfffff;
        {reqAddr, cwData} = 26'h0000000;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_b = 1'b1;
        hostMode = 2'h0;
        t_mirror();
        t_parity();
        t_mode();
        report_and_stop();
    end
endmodule // testbench
